//--- gxp_top.sv
// Purpose: eight-pin gpio expander behind a two-wire serial slave
// Assumes: SCL and SDA are slow pins sampled by CLK_I; no clock stretching
// Notes:   local status port reports alert and write events
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
module gxp_top (
  // clock and power-on reset
  input  wire logic                        CLK_I,
  input  wire logic                        RST_N_I,
  // external reset and address straps
  input  wire logic                        EXT_RST_N_I,
  input  wire logic                        ADDR_STRAP_LOW_I,
  input  wire logic                        ADDR_STRAP_HIGH_I,
  // serial bus
  input  wire logic                        SCL_I,
  input  wire logic                        SDA_I,
  output logic                             SDA_O,
  output logic                             SDA_OE_O,
  // alert pin, open drain
  output logic                             INT_O,
  output logic                             INT_OE_O,
  // port pins
  input  wire logic [7:0]                  PORT_PIN_I,
  output logic      [7:0]                  PORT_PIN_O,
  output logic      [7:0]                  PORT_PIN_OE_O,
  // local status port
  input  wire logic [1:0]                  BUS_ADDR_I,
  input  wire logic [7:0]                  BUS_WDATA_I,
  input  wire logic                        BUS_WR_I,
  input  wire logic                        BUS_RD_I,
  output logic      [7:0]                  BUS_RDATA_O,
  output logic                             IRQ_O
);
  import gxp_pkg::*;

  logic [2:0]           scl_q;
  logic [2:0]           sda_q;
  logic [1:0]           ext_q;
  logic [1:0]           strap_q1;
  logic [1:0]           strap_q2;
  logic [7:0]           pin_s1;
  logic [7:0]           pin_s2;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_c;
  logic                 stop_c;
  logic                 clr;
  gxp_state_e           st_r;
  logic [3:0]           cnt_r;
  logic [7:0]           sh_r;
  logic [7:0]           tx_r;
  logic [7:0]           addr_r;
  logic [7:0]           ptr_r;
  logic                 rw_r;
  logic                 nack_r;
  logic                 sda_oe_r;
  logic [7:0]           out_r;
  logic [7:0]           pol_r;
  logic [7:0]           en_r;
  logic [7:0]           snap_r;
  logic [1:0]           init_r;
  logic                 alert_r;
  logic                 alert_d;
  logic                 wr_evt;
  logic [6:0]           own_addr;
  logic [EV_BITS-1:0]   sts_r;
  logic [EV_BITS-1:0]   mask_r;
  logic [EV_BITS-1:0]   ev;
  logic [7:0]           rdata_r;
  logic                 irq_r;
  logic [7:0]           rd_val;

  // serial read value of a register
  function automatic logic [7:0] reg_value(input logic [7:0] p, input logic [7:0] pins,
                                           input logic [7:0] pol, input logic [7:0] outv,
                                           input logic [7:0] en);
    unique case (p)
      PTR_INPUT:  reg_value = pins ^ pol;
      PTR_OUTPUT: reg_value = outv;
      PTR_POL:    reg_value = pol;
      PTR_DIR:    reg_value = ~en;
      default:    reg_value = 8'h00;
    endcase
  endfunction

  // one read value feeds both the shifter and its first bit
  assign rd_val = reg_value(ptr_r, pin_s2, pol_r, out_r, en_r);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q    <= 3'h7;
      sda_q    <= 3'h7;
      ext_q    <= 2'h0;
      strap_q1 <= 2'h0;
      strap_q2 <= 2'h0;
      pin_s1   <= 8'h00;
      pin_s2   <= 8'h00;
    end else begin
      scl_q    <= {scl_q[1:0], SCL_I};
      sda_q    <= {sda_q[1:0], SDA_I};
      ext_q    <= {ext_q[0], EXT_RST_N_I};
      strap_q1 <= {ADDR_STRAP_HIGH_I, ADDR_STRAP_LOW_I};
      strap_q2 <= strap_q1;
      pin_s1   <= PORT_PIN_I;
      pin_s2   <= pin_s1;
    end
  end

  // edges are read from stages two and three only
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign clr      = ~ext_q[1];
  assign own_addr = {ADDR_FIXED, strap_q2};
  assign wr_evt   = (st_r == ST_WR) && scl_fall && (cnt_r == 4'h8);

  // serial slave, any scl rate far below clk
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      addr_r   <= 8'h00;
      ptr_r    <= PTR_INPUT;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (clr || stop_c) begin
      st_r     <= ST_IDLE;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
      if (clr) begin
        ptr_r <= PTR_INPUT;
      end
    end else if (start_c) begin
      st_r     <= ST_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else begin
      if (scl_rise && (st_r == ST_ADDR || st_r == ST_CMD || st_r == ST_WR || st_r == ST_RD)) begin
        sh_r  <= {sh_r[6:0], sda_q[1]};
        cnt_r <= cnt_r + 4'h1;
      end
      if (scl_rise && st_r == ST_RD_ACK) begin
        nack_r <= sda_q[1];
      end
      if (scl_fall) begin
        unique case (st_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_ADDR: begin
            if (cnt_r == 4'h8) begin
              addr_r <= sh_r;
              rw_r   <= sh_r[0];
              if (sh_r[7:1] == own_addr) begin
                st_r     <= ST_ADDR_ACK;
                sda_oe_r <= 1'b1;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              tx_r     <= rd_val;
              sda_oe_r <= ~rd_val[7];
              st_r     <= ST_RD;
            end else begin
              sda_oe_r <= 1'b0;
              st_r     <= ST_CMD;
            end
          end
          ST_CMD: begin
            if (cnt_r == 4'h8) begin
              ptr_r    <= sh_r;
              sda_oe_r <= 1'b1;
              st_r     <= ST_CMD_ACK;
            end
          end
          ST_WR: begin
            if (cnt_r == 4'h8) begin
              sda_oe_r <= 1'b1;
              st_r     <= ST_WR_ACK;
            end
          end
          ST_CMD_ACK, ST_WR_ACK: begin
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
            st_r     <= ST_WR;
          end
          ST_RD: begin
            if (cnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              st_r     <= ST_RD_ACK;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
          ST_RD_ACK: begin
            cnt_r <= 4'h0;
            // a nack ends the read; stay off the bus until the next start
            if (nack_r) begin
              sda_oe_r <= 1'b0;
              st_r     <= ST_IDLE;
            end else begin
              tx_r     <= rd_val;
              sda_oe_r <= ~rd_val[7];
              st_r     <= ST_RD;
            end
          end
        endcase
      end
    end
  end

  // drivers start off, output latch starts high so nothing glitches
  // register writes, input register read only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_r <= RST_OUTPUT;
      pol_r <= RST_POL;
      en_r  <= ~RST_DIR;
    end else if (clr) begin
      out_r <= RST_OUTPUT;
      pol_r <= RST_POL;
      en_r  <= ~RST_DIR;
    end else if (wr_evt) begin
      unique case (ptr_r)
        PTR_OUTPUT: out_r <= sh_r;
        PTR_POL:    pol_r <= sh_r;
        PTR_DIR:    en_r  <= ~sh_r;
        default:    out_r <= out_r;
      endcase
    end
  end

  // snapshot taken at the read acknowledge
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      snap_r <= 8'h00;
      init_r <= 2'h0;
    end else if (clr) begin
      snap_r <= pin_s2;
      init_r <= 2'h0;
    end else if (init_r != INIT_DONE) begin
      snap_r <= pin_s2;
      init_r <= init_r + 2'h1;
    end else if (st_r == ST_RD_ACK && scl_rise && ptr_r == PTR_INPUT) begin
      snap_r <= pin_s2;
    end
  end

  // alert on mismatch of input pins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      alert_r <= 1'b0;
      alert_d <= 1'b0;
    end else begin
      alert_r <= (init_r == INIT_DONE) && !clr && (|((pin_s2 ^ snap_r) & ~en_r));
      alert_d <= alert_r;
    end
  end

  // local status: set wins over write-one-clear
  assign ev = {wr_evt, alert_r & ~alert_d};

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sts_r   <= '0;
      mask_r  <= '0;
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      if (BUS_WR_I && BUS_ADDR_I == LOC_STATUS) begin
        sts_r <= (sts_r & ~BUS_WDATA_I[EV_BITS-1:0]) | ev;
      end else begin
        sts_r <= sts_r | ev;
      end
      if (BUS_WR_I && BUS_ADDR_I == LOC_MASK) begin
        mask_r <= BUS_WDATA_I[EV_BITS-1:0];
      end
      rdata_r <= 8'h00;
      if (BUS_RD_I) begin
        unique case (BUS_ADDR_I)
          LOC_STATUS: rdata_r <= {6'h00, sts_r};
          LOC_MASK:   rdata_r <= {6'h00, mask_r};
          LOC_VIEW:   rdata_r <= {3'h0, alert_r, st_r};
          default:    rdata_r <= 8'h00;
        endcase
      end
      irq_r <= |(sts_r & mask_r);
    end
  end

  // only pull low; latched pin drive
  assign INT_O         = 1'b0;
  assign INT_OE_O      = alert_r;
  assign SDA_O         = 1'b0;
  assign SDA_OE_O      = sda_oe_r;
  assign PORT_PIN_O    = out_r;
  assign PORT_PIN_OE_O = en_r;
  assign BUS_RDATA_O   = rdata_r;
  assign IRQ_O         = irq_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_alert_mismatch: assert property ((init_r == INIT_DONE) && !clr && |((pin_s2 ^ snap_r) & ~en_r) |=> INT_OE_O)
    else $error("alert missing on input mismatch");
  a_alert_quiet: assert property (INT_OE_O |-> $past(|((pin_s2 ^ snap_r) & ~en_r)))
    else $error("alert pulled without cause");
  a_ext_reset_hold: assert property (clr |=> (st_r == ST_IDLE && en_r == 8'h00 && out_r == RST_OUTPUT && !INT_OE_O))
    else $error("external reset did not hold defaults");
  a_pins_stay_input: assert property ($changed(en_r) |-> $past(wr_evt) || $past(clr))
    else $error("pin driver changed without a write");
  a_addr_match_ack: assert property (st_r == ST_ADDR_ACK |-> addr_r[7:1] == own_addr)
    else $error("acknowledged a foreign address");
  a_dir_write: assert property (wr_evt && ptr_r == PTR_DIR && !clr |=> PORT_PIN_OE_O == ~$past(sh_r))
    else $error("direction write not applied");
  a_read_ack_snap: assert property (st_r == ST_RD_ACK && scl_rise && ptr_r == PTR_INPUT && !clr
                                    |=> snap_r == $past(pin_s2))
    else $error("input read did not recapture");
  a_sda_on_fall: assert property ($rose(SDA_OE_O) |-> $past(scl_fall))
    else $error("sda driven outside a clock fall");
  a_strap_addr: assert property (own_addr[1:0] == strap_q2 && own_addr[6:2] == ADDR_FIXED)
    else $error("own address wrong");
  a_out_latched: assert property (!wr_evt && !clr |=> $stable(out_r))
    else $error("output latch moved without a write");

  c_write_dir: cover property (wr_evt && ptr_r == PTR_DIR);
  c_read_input: cover property (st_r == ST_RD_ACK && scl_rise && ptr_r == PTR_INPUT);
  c_alert_clear: cover property (INT_OE_O ##1 !INT_OE_O);
  c_irq: cover property ($rose(IRQ_O));
  c_ext_reset: cover property ($rose(clr));
endmodule // gxp_top

//--- gxp_pkg.sv
// Purpose: shared constants for the two-wire gpio expander
// Assumes: one 250 MHz clock samples every pin
// Notes:   register map of the serial side and of the local status port
//
// Notes on behaviour
// - four byte registers are reachable over the serial bus: input, output, polarity and direction.
// - the alert is asserted while any input pin differs from the captured input value.
// - the alert pin is active low and open drain, only ever pulled low.
// - power-on reset loads all register defaults and idles the serial state machine.
// - while the external reset pin is low the output, polarity, direction and pointer registers and the serial state machine stay at defaults.
// - two strap pins give the two low bits of the slave address.
// - after power-up every port pin is an input with its driver off.
// - no port pin changes level during power-up.
// - the serial slave works at bus clock rates up to 400 kHz.
// - output pins are driven from latched register values until rewritten.
// - eight port pins, each independently an input or an output.
// - the address is binary 11100 plus the two straps; a high direction bit means read.
// - the first written byte picks the register: 00h input, 01h output, 02h polarity, 03h direction.
// - a direction bit of one makes the pin an input, zero makes it an output.
// - the alert clears when the pin returns or at the acknowledge bit of an input register read.
package gxp_pkg;
  // serial register pointers
  localparam logic [7:0] PTR_INPUT  = 8'h00;
  localparam logic [7:0] PTR_OUTPUT = 8'h01;
  localparam logic [7:0] PTR_POL    = 8'h02;
  localparam logic [7:0] PTR_DIR    = 8'h03;
  // reset values
  localparam logic [7:0] RST_OUTPUT = 8'hFF;
  localparam logic [7:0] RST_POL    = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'hFF;
  localparam logic [4:0] ADDR_FIXED = 5'h1C;
  // local status port
  localparam logic [1:0] LOC_STATUS = 2'h0;
  localparam logic [1:0] LOC_MASK   = 2'h1;
  localparam logic [1:0] LOC_VIEW   = 2'h2;
  localparam int unsigned EV_ALERT  = 0;
  localparam int unsigned EV_WRITE  = 1;
  localparam int unsigned EV_BITS   = 2;
  localparam logic [1:0] INIT_DONE  = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } gxp_state_e;
endpackage

//--- gxp_i2c_mst.sv
// Purpose: two-wire bus master model facing the expander
// Assumes: 12 clk per bit (48 ns), scl low for 8 clk and high for 4 clk
// Notes:   sda is open drain; scl stands high between frames
`timescale 1ns/100ps
module gxp_i2c_mst (
  // clock
  input  wire logic clk_i,
  // bus wires
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // long low phase covers the slave's synchroniser and answer delay
  task automatic bit_io(input logic b, output logic r);
    scl_o <= 1'b0;
    wt(4);
    sda_oe_o <= ~b;
    wt(4);
    scl_o <= 1'b1;
    wt(2);
    r = sda_i;
    wt(2);
  endtask
  // start also serves as repeated start
  task automatic start();
    scl_o <= 1'b0;
    wt(4);
    sda_oe_o <= 1'b0;
    wt(4);
    scl_o <= 1'b1;
    wt(4);
    sda_oe_o <= 1'b1;
    wt(4);
  endtask
  task automatic stop();
    scl_o <= 1'b0;
    wt(4);
    sda_oe_o <= 1'b1;
    wt(4);
    scl_o <= 1'b1;
    wt(4);
    sda_oe_o <= 1'b0;
    wt(4);
  endtask
  // msb first, ninth bit is the slave's ack
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic get(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule // gxp_i2c_mst

//--- tb.sv
// Purpose: self-checking bench for the gpio expander
// Assumes: design assertions live in the design files
// Notes:   register model in plain variables, pins resolved in the bench
`timescale 1ns/100ps
module tb;
  import gxp_pkg::*;
  logic        clk, rst_n, ext_rst_n, s_lo, s_hi, scl, sda_oe_m, bus_wr, bus_rd, ack;
  logic        sda_oe_d, sda_o, int_o, int_oe, irq;
  logic [1:0]  bus_addr;
  logic [7:0]  bus_wdata, pin_drv, pin_o, pin_oe, rdata, v, m_out, m_pol, m_dir;
  logic [31:0] seed;
  logic [1:0]  sx;
  int          n_errors, num_checks;
  // sda has a pull-up, any party may pull it low
  wire         sda = ~(sda_oe_m | sda_oe_d);
  wire [7:0]   pins = (pin_oe & pin_o) | (~pin_oe & pin_drv);
  gxp_top i_gxp_top (.CLK_I(clk), .RST_N_I(rst_n), .EXT_RST_N_I(ext_rst_n), .ADDR_STRAP_LOW_I(s_lo),
    .ADDR_STRAP_HIGH_I(s_hi), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe_d), .INT_O(int_o),
    .INT_OE_O(int_oe), .PORT_PIN_I(pins), .PORT_PIN_O(pin_o), .PORT_PIN_OE_O(pin_oe), .BUS_ADDR_I(bus_addr),
    .BUS_WDATA_I(bus_wdata), .BUS_WR_I(bus_wr), .BUS_RD_I(bus_rd), .BUS_RDATA_O(rdata), .IRQ_O(irq));
  gxp_i2c_mst i_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(sda_oe_m));
  always #2 clk = ~clk;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 8'(seed);
  endfunction
  function automatic logic [7:0] mexp(input logic [7:0] p);
    case (p)
      PTR_INPUT:  return ((~m_dir & m_out) | (m_dir & pin_drv)) ^ m_pol;
      PTR_OUTPUT: return m_out;
      PTR_POL:    return m_pol;
      PTR_DIR:    return m_dir;
      default:    return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic addr(input logic rd);
    i_mst.start();
    i_mst.put({ADDR_FIXED, s_hi, s_lo, rd}, ack);
    chk({7'h0, ack}, 8'h00, "addr ack");
  endtask
  task automatic sw(input logic [7:0] p, input logic [7:0] d);
    addr(1'b0);
    i_mst.put(p, ack);
    chk({7'h0, ack}, 8'h00, "pointer ack");
    i_mst.put(d, ack);
    chk({7'h0, ack}, 8'h00, "data ack");
    i_mst.stop();
    if (p == PTR_OUTPUT) m_out = d;
    if (p == PTR_POL) m_pol = d;
    if (p == PTR_DIR) m_dir = d;
  endtask
  task automatic sr(input logic [7:0] p);
    addr(1'b0);
    i_mst.put(p, ack);
    addr(1'b1);
    i_mst.get(1'b1, v);
    i_mst.stop();
    chk(v, mexp(p), "reg read");
  endtask
  task automatic bwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic brd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(rdata, e, "local read");
  endtask
  task automatic wint(input logic e);
    for (int i = 0; i < 40 && int_oe !== e; i++) @(posedge clk);
    chk({7'h0, int_oe}, {7'h0, e}, "alert");
    if (int_oe !== e) stop_test();
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    {clk, rst_n, ext_rst_n, s_lo, s_hi, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    ext_rst_n = 1'b1;
    seed = 32'h13ff_9f2c;
    pin_drv = xs();
    {m_out, m_pol, m_dir} = {RST_OUTPUT, RST_POL, RST_DIR};
    #5 chk(pin_oe, 8'h00, "inputs at reset");
    chk(pin_o, 8'hFF, "no glitch");
    chk({6'h0, int_oe, sda_oe_d}, 8'h00, "idle at reset");
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    i_mst.wt(6);
    // defaults, with one unmapped pointer
    for (int p = 0; p < 5; p++) sr(8'(p));
    // foreign addresses must not be acknowledged
    for (int k = 0; k < 2; k++) begin
      i_mst.start();
      i_mst.put({ADDR_FIXED ^ 5'(k), ~s_hi, s_lo, 1'b0}, ack);
      chk({7'h0, ack}, 8'h01, "foreign addr");
      i_mst.put(8'h01, ack);
      i_mst.put(8'h00, ack);
      chk({7'h0, ack}, 8'h01, "ignored after foreign");
      i_mst.stop();
    end
    sr(PTR_OUTPUT);
    // random strap start, every address still visited once
    sx = 2'(xs());
    for (int k = 0; k < 4; k++) begin
      s_lo <= k[0] ^ sx[0];
      s_hi <= k[1] ^ sx[1];
      pin_drv <= xs();
      i_mst.wt(8);
      sw(PTR_POL, xs());
      sw(PTR_DIR, xs());
      sw(PTR_OUTPUT, xs());
      // input register writes have no effect
      sw(PTR_INPUT, xs());
      for (int p = 0; p < 4; p++) sr(8'(p));
      chk(pin_oe, ~m_dir, "direction");
      chk(pin_o, m_out, "latched out");
    end
    sw(PTR_DIR, 8'hFF);
    sw(PTR_POL, 8'h00);
    pin_drv <= 8'hA5;
    i_mst.wt(8);
    sr(PTR_INPUT);
    bwr(LOC_MASK, 8'h01);
    bwr(LOC_STATUS, 8'h03);
    pin_drv <= 8'hB5;
    wint(1'b1);
    chk({7'h0, int_o}, 8'h00, "open drain");
    brd(LOC_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h01, "irq up");
    pin_drv <= 8'hA5;
    wint(1'b0);
    pin_drv <= 8'hA4;
    wint(1'b1);
    sr(PTR_INPUT);
    chk({7'h0, int_oe}, 8'h00, "cleared by read");
    bwr(LOC_STATUS, 8'h01);
    i_mst.wt(2);
    chk({7'h0, irq}, 8'h00, "irq down");
    brd(2'h3, 8'h00);
    sw(PTR_DIR, 8'h00);
    sw(PTR_OUTPUT, 8'h3C);
    ext_rst_n <= 1'b0;
    i_mst.wt(5);
    chk(pin_oe, 8'h00, "ext reset dir");
    chk(pin_o, 8'hFF, "ext reset out");
    ext_rst_n <= 1'b1;
    i_mst.wt(6);
    {m_out, m_pol, m_dir} = {RST_OUTPUT, RST_POL, RST_DIR};
    sr(PTR_DIR);
    sr(PTR_OUTPUT);
    // second power-on reset in mid-run; local mask clears as well
    sw(PTR_DIR, 8'h0F);
    rst_n <= 1'b0;
    i_mst.wt(2);
    chk(pin_oe, 8'h00, "dir in reset");
    chk({6'h0, int_oe, sda_oe_d}, 8'h00, "idle in reset");
    rst_n <= 1'b1;
    {m_out, m_pol, m_dir} = {RST_OUTPUT, RST_POL, RST_DIR};
    i_mst.wt(6);
    brd(LOC_MASK, 8'h00);
    sr(PTR_DIR);
    stop_test();
  end
endmodule // tb
